// ### hw/spi_req_pkg.sv
// Package: constants and types for the SPI request and exception handler
package spi_req_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
  localparam int BIT_RSVD15 = 15;
  localparam int BIT_ACCEL = 14;
  localparam int BIT_AXIS = 13;
  localparam int BIT_OC = 12;
  localparam int BIT_SD = 2;
  localparam int BIT_ARM = 1;
  localparam int ADDR_HI = 12;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int ZERO_HI = 11;
  localparam int ZERO_LO = 3;

  // ----------------------------------------------------------------
  // Configuration register fields and special addresses
  // ----------------------------------------------------------------
  localparam int CFG_SD_BIT = 4;
  localparam int CFG_ACFG2_BIT = 2;
  localparam int CFG_ACFG1_BIT = 1;
  localparam int CFG_LOCK_BIT = 7;
  localparam logic [4:0] ADDR_STATUS = 5'h0e;
  localparam logic [4:0] ADDR_CONTROL = 5'h0a;

  // ----------------------------------------------------------------
  // Response codes in bits 15..12, accel status in bits 11..10, and the reset reply frame
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_SPI_ERR = 4'hf;
  localparam logic [3:0] CODE_MISO_ERR = 4'he;
  localparam logic [3:0] CODE_INV_REG = 4'hd;
  localparam logic [3:0] CODE_INV_ACCEL = 4'hc;
  localparam logic [3:0] CODE_INT_ERR = 4'hb;
  localparam logic [3:0] CODE_ST_ERR = 4'ha;
  localparam logic [3:0] CODE_ACCEL = 4'h1;
  localparam logic [3:0] CODE_WR_ACK = 4'h2;
  localparam logic [3:0] CODE_RD_DATA = 4'h3;
  localparam logic [1:0] STAT_NORMAL = 2'h0;
  localparam logic [1:0] STAT_OVER = 2'h2;
  localparam logic [FRAME_BITS-1:0] TX_RESET = 16'hf000;

  typedef enum logic [1:0] {
    SEL_X_OC,
    SEL_X_RAW,
    SEL_Y_OC,
    SEL_Y_RAW
  } data_sel_t;

  typedef struct packed {
    logic init_pending;
    logic internal_fault;
    logic crc_error;
    logic selftest_error;
    logic offset_over;
    logic sd_over;
  } fault_t;

  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [7:0] data;
  } wr_req_t;

endpackage

// ### hw/spi_request_exception_handler.sv
// SPI command decoder with prioritised exception responses
`timescale 1ns/100ps
module spi_request_exception_handler #(
  parameter logic [31:0] WRITABLE_MASK = 32'h0000_fc00,
  parameter logic [31:0] READABLE_MASK = 32'hffff_ffff
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_miso_readback,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic [7:0] i_dev_config,
  input wire spi_req_pkg::fault_t i_faults,
  input wire logic [9:0] i_accel_data,
  input wire logic [7:0] i_rd_data,
  output logic [4:0] o_rd_addr,
  output spi_req_pkg::wr_req_t o_wr,
  output spi_req_pkg::data_sel_t o_data_sel,
  output logic o_arm_update,
  output logic o_status_read,
  output logic o_pcm_disable,
  output logic o_reset_occurred_flag,
  output logic o_readback_mismatch_flag
);
  import spi_req_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_n_sync_r;
  logic [1:0] sclk_sync_r;
  logic [1:0] mosi_sync_r;
  logic [1:0] rb_sync_r;
  logic cs_n_d_r;
  logic sclk_d_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_n_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      mosi_sync_r <= 2'h0;
      rb_sync_r <= 2'h0;
      cs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_n_sync_r <= {cs_n_sync_r[0], i_cs_n};
      sclk_sync_r <= {sclk_sync_r[0], i_sclk};
      mosi_sync_r <= {mosi_sync_r[0], i_mosi};
      rb_sync_r <= {rb_sync_r[0], i_miso_readback};
      cs_n_d_r <= cs_n_sync_r[1];
      sclk_d_r <= sclk_sync_r[1];
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_n_s = cs_n_sync_r[1];
  assign sclk_s = sclk_sync_r[1];
  assign frame_start = cs_n_d_r && !cs_n_s;
  assign frame_end = !cs_n_d_r && cs_n_s;
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_r;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_r;

  // ----------------------------------------------------------------
  // Shifters, edge count, framing and readback checks
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_r;
  logic [FRAME_BITS-1:0] tx_r;
  logic [FRAME_BITS-1:0] next_tx_r;
  logic [CNT_W-1:0] edge_cnt_r;
  logic frame_err_r;
  logic rb_err_r;

  // MOSI in on rising SCLK, MISO moves on falling SCLK, MSB first
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_r <= '0;
      tx_r <= TX_RESET;
      edge_cnt_r <= '0;
    end else if (frame_start) begin
      tx_r <= next_tx_r;
      edge_cnt_r <= '0;
    end else begin
      if (sclk_rise) begin
        rx_r <= {rx_r[FRAME_BITS-2:0], mosi_sync_r[1]};
        if (edge_cnt_r != 5'h1f) begin
          edge_cnt_r <= edge_cnt_r + 5'h01;
        end
      end
      // A fall before the first rise is a framing fault; shifting then would misalign the reply
      if (sclk_fall && (edge_cnt_r != '0)) begin
        tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // SCLK level is checked at both chip-select edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_err_r <= 1'b0;
    end else if (frame_start) begin
      frame_err_r <= sclk_s;
    end else if (frame_end && sclk_s) begin
      frame_err_r <= 1'b1;
    end
  end

  // The bit under test has been on the pin for several clocks by the rising edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rb_err_r <= 1'b0;
    end else if (frame_start) begin
      rb_err_r <= 1'b0;
    end else if (sclk_rise && (rb_sync_r[1] != tx_r[FRAME_BITS-1])) begin
      rb_err_r <= 1'b1;
    end
  end

  assign o_miso = tx_r[FRAME_BITS-1];
  assign o_miso_oe = !cs_n_s;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic is_accel;
  logic is_write;
  logic [4:0] addr;
  logic spi_err;
  logic cfg_mismatch;
  logic wr_allowed;
  logic rd_allowed;
  logic write_lock_flag;
  logic rd_ok;
  logic status_rd_ok;
  logic rbm_flag_r;
  logic rst_flag_r;

  assign is_accel = rx_r[BIT_ACCEL];
  assign is_write = rx_r[BIT_AXIS];
  assign addr = rx_r[ADDR_HI:ADDR_LO];
  assign o_rd_addr = addr;
  assign write_lock_flag = i_dev_config[CFG_LOCK_BIT];
  assign cfg_mismatch = (rx_r[BIT_SD] != i_dev_config[CFG_SD_BIT]) ||
                        (rx_r[BIT_ARM] != (i_dev_config[CFG_ACFG2_BIT] | i_dev_config[CFG_ACFG1_BIT]));

  always_comb begin
    spi_err = frame_err_r || (edge_cnt_r != FRAME_EDGES);
    if (!(^rx_r)) begin
      spi_err = 1'b1;
    end
    if (is_accel && (rx_r[BIT_RSVD15] || (rx_r[ZERO_HI:ZERO_LO] != '0))) begin
      spi_err = 1'b1;
    end
    if (!is_accel && !is_write && (rx_r[DATA_HI:0] != '0)) begin
      spi_err = 1'b1;
    end
  end

  // Control register stays writable under the lock so a lock can still be lifted by reset logic
  assign wr_allowed = WRITABLE_MASK[addr] && (!write_lock_flag || (addr == ADDR_CONTROL));
  assign rd_allowed = READABLE_MASK[addr];
  assign rd_ok = frame_end && !is_accel && !is_write && !spi_err && !rb_err_r && rd_allowed;
  assign status_rd_ok = rd_ok && (addr == ADDR_STATUS);

  // ----------------------------------------------------------------
  // Reply selection by exception priority
  // ----------------------------------------------------------------
  logic [3:0] code;
  logic [11:0] payload;
  logic arm_ok;

  always_comb begin
    arm_ok = 1'b0;
    payload = '0;
    if (spi_err) begin
      code = CODE_SPI_ERR;
    end else if (rb_err_r) begin
      code = CODE_MISO_ERR;
    end else if (is_accel) begin
      if (cfg_mismatch) begin
        code = CODE_INV_ACCEL;
      end else if (i_faults.init_pending || rst_flag_r || i_faults.crc_error) begin
        code = CODE_INT_ERR;
      end else if (i_faults.selftest_error || i_faults.internal_fault) begin
        code = CODE_ST_ERR;
      end else begin
        code = CODE_ACCEL;
        arm_ok = 1'b1;
        payload = {(i_faults.offset_over || i_faults.sd_over) ? STAT_OVER : STAT_NORMAL, i_accel_data};
      end
    end else if (is_write) begin
      code = wr_allowed ? CODE_WR_ACK : CODE_INV_REG;
      payload = {4'h0, rx_r[DATA_HI:0]};
    end else begin
      code = rd_allowed ? CODE_RD_DATA : CODE_INV_REG;
      payload = {4'h0, i_rd_data};
    end
  end

  // Reset value makes the first reply after any reset an SPI-error frame
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      next_tx_r <= TX_RESET;
    end else if (frame_end) begin
      next_tx_r <= {code, payload};
    end
  end

  // ----------------------------------------------------------------
  // Side effects of a decoded frame
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wr <= '0;
    end else begin
      o_wr.valid <= frame_end && !is_accel && is_write && !spi_err && wr_allowed;
      o_wr.addr <= addr;
      o_wr.data <= rx_r[DATA_HI:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arm_update <= 1'b0;
      o_data_sel <= SEL_X_OC;
    end else begin
      o_arm_update <= frame_end && arm_ok;
      if (frame_end && is_accel && !spi_err) begin
        o_data_sel <= data_sel_t'({rx_r[BIT_AXIS], rx_r[BIT_OC]});
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_read <= 1'b0;
    end else begin
      o_status_read <= status_rd_ok;
    end
  end

  // New mismatch wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rbm_flag_r <= 1'b0;
    end else if (sclk_rise && (rb_sync_r[1] != tx_r[FRAME_BITS-1])) begin
      rbm_flag_r <= 1'b1;
    end else if (status_rd_ok) begin
      rbm_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_flag_r <= 1'b1;
    end else if (status_rd_ok) begin
      rst_flag_r <= 1'b0;
    end
  end

  assign o_readback_mismatch_flag = rbm_flag_r;
  assign o_reset_occurred_flag = rst_flag_r;
  // Init pending clears on its own in the source logic; no latch here
  assign o_pcm_disable = i_faults.init_pending || rst_flag_r;

endmodule

// ### bench/spi_req_asserts.sv
// Checker for the SPI request and exception handler ports
`timescale 1ns/100ps
module spi_req_asserts (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire spi_req_pkg::fault_t i_faults,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire spi_req_pkg::wr_req_t o_wr,
  input wire spi_req_pkg::data_sel_t o_data_sel,
  input wire logic o_arm_update,
  input wire logic o_status_read,
  input wire logic o_pcm_disable,
  input wire logic o_reset_occurred_flag,
  input wire logic o_readback_mismatch_flag
);
  import spi_req_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wr_after_frame_a: assert property (o_wr.valid |-> $past(i_cs_n, 3) && !o_arm_update && !o_status_read)
    else $error("write pulse outside frame end");
  wr_one_cycle_a: assert property (o_wr.valid |=> !o_wr.valid)
    else $error("write pulse too long");
  arm_one_cycle_a: assert property (o_arm_update |=> !o_arm_update)
    else $error("arming pulse too long");
  pcm_init_a: assert property (i_faults.init_pending |-> ##[0:2] o_pcm_disable)
    else $error("pulse code not disabled");
  pcm_reset_a: assert property (!o_pcm_disable |-> !o_reset_occurred_flag)
    else $error("pulse code on with reset flag");
  rst_clear_a: assert property (o_status_read |-> ##[0:1] !o_reset_occurred_flag)
    else $error("reset flag kept after status read");
  rst_hold_a: assert property (o_reset_occurred_flag && !o_status_read |=> o_reset_occurred_flag || o_status_read)
    else $error("reset flag dropped");
  rb_hold_a: assert property (o_readback_mismatch_flag && !o_status_read |=> o_readback_mismatch_flag || o_status_read)
    else $error("readback flag dropped");
  oe_idle_a: assert property (i_cs_n [*4] |-> !o_miso_oe)
    else $error("output enabled while deselected");
  miso_still_a: assert property ((i_sclk && !i_cs_n) [*4] ##0 $past(!i_cs_n, 6) |-> $stable(o_miso))
    else $error("data out moved while clock high");
  sel_change_a: assert property (!$stable(o_data_sel) |-> $past(i_cs_n, 3))
    else $error("data select moved inside frame");
  cover property (o_arm_update);
  cover property (o_wr.valid);
  cover property (o_status_read);
endmodule
bind spi_request_exception_handler spi_req_asserts u_chk (.i_clk, .i_arst_n, .i_cs_n, .i_sclk, .i_faults,
  .o_miso, .o_miso_oe, .o_wr, .o_data_sel, .o_arm_update, .o_status_read, .o_pcm_disable,
  .o_reset_occurred_flag, .o_readback_mismatch_flag);

// ### bench/spi_host_model.sv
// Mode 0 SPI master model driving the device pins
`timescale 1ns/100ps
module spi_host_model (
  input wire logic i_clk,
  input wire logic i_miso,
  input wire logic i_oe,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_rb
);
  logic flip = 1'b0;
  // Undriven line shows the inverse so a stale bit never passes
  assign o_rb = i_oe ? i_miso ^ flip : ~i_miso;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic xfer(input logic [15:0] c, input int n, input logic bad, input logic hi, output logic [15:0] r);
    flip = bad;
    r = 16'h0000;
    o_sclk = hi;
    half(1);
    o_cs_n = 1'b0;
    half(4);
    for (int i = 0; i < n; i++) begin
      o_mosi = c[15-i];
      o_sclk = 1'b0;
      half(4);
      o_sclk = 1'b1;
      r[15-i] = i_miso;
      half(4);
    end
    o_sclk = 1'b0;
    o_mosi = ~o_mosi;
    half(4);
    o_cs_n = 1'b1;
    flip = 1'b0;
    half(8);
  endtask
endmodule

// ### bench/tb_spi_request_exception_handler.sv
// Self-checking bench for the SPI request and exception handler
`timescale 1ns/100ps
module tb_spi_request_exception_handler;
  import spi_req_pkg::*;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_cs_n, i_sclk, i_mosi, i_miso_readback, o_miso, o_miso_oe;
  logic [7:0] i_dev_config = 8'h00;
  fault_t i_faults = '0;
  logic [9:0] i_accel_data = 10'h000;
  logic [7:0] i_rd_data = 8'h00;
  logic [4:0] o_rd_addr;
  wr_req_t o_wr, wl;
  data_sel_t o_data_sel;
  logic o_arm_update, o_status_read, o_pcm_disable, o_reset_occurred_flag, o_readback_mismatch_flag;
  logic [15:0] rsp;
  logic [7:0] d;
  logic [9:0] ad = 10'h000;
  int err_count = 0;
  int checks_done = 0;
  int nw = 0;
  int na = 0;
  always #20 i_clk = ~i_clk;
  spi_request_exception_handler dut (.i_clk, .i_arst_n, .i_cs_n, .i_sclk, .i_mosi, .i_miso_readback, .o_miso,
    .o_miso_oe, .i_dev_config, .i_faults, .i_accel_data, .i_rd_data, .o_rd_addr, .o_wr, .o_data_sel,
    .o_arm_update, .o_status_read, .o_pcm_disable, .o_reset_occurred_flag, .o_readback_mismatch_flag);
  spi_host_model host (.i_clk, .i_miso(o_miso), .i_oe(o_miso_oe), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_mosi(i_mosi), .o_rb(i_miso_readback));
  always @(posedge i_clk) begin
    if (o_wr.valid === 1'b1) begin
      nw++;
      wl = o_wr;
    end
    if (o_arm_update === 1'b1) na++;
  end
  function automatic logic [15:0] par(input logic [15:0] c, input int s);
    c[s] = ~^c;
    return c;
  endfunction
  function automatic logic [15:0] fa(input logic [1:0] s, input logic fs = 1'b0, input logic fm = 1'b0);
    return par({2'b01, s, 9'h000, i_dev_config[4] ^ fs, (i_dev_config[2] | i_dev_config[1]) ^ fm, 1'b0}, 0);
  endfunction
  function automatic logic [15:0] fr(input logic w, input logic [4:0] a, input logic [7:0] v);
    return par({2'b00, w, a, v}, 15);
  endfunction
  task automatic mis(input string m);
    err_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  // Reply checked is the one to the previous command
  task automatic go(input logic [15:0] c, input logic [3:0] ec, input logic [11:0] ep, input logic up,
    input int n = 16, input logic bad = 1'b0, input logic hi = 1'b0);
    host.xfer(c, n, bad, hi, rsp);
    checks_done++;
    if (rsp[15:12] !== ec || (up && rsp[11:0] !== ep)) mis($sformatf("reply %h", rsp));
  endtask
  task automatic cb(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) mis($sformatf("got %h want %h", g, e));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    mis("timeout");
    results();
  end
  initial begin
    d = 8'($urandom(32'hf36e));
    repeat (12) @(posedge i_clk);
    @(negedge i_clk) i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rd_data = 8'($urandom);
    go(fr(1'b0, ADDR_STATUS, 8'h00), CODE_SPI_ERR, 12'h000, 1'b0);
    cb(o_reset_occurred_flag, 0);
    cb(o_pcm_disable, 0);
    for (int i = 0; i < 8; i++) begin
      go(fa(i[1:0]), i ? CODE_ACCEL : CODE_RD_DATA, i ? {STAT_NORMAL, ad} : {4'h0, i_rd_data}, 1);
      ad = i_accel_data;
      cb(o_data_sel, i[1:0]);
      i_accel_data = 10'($urandom);
      i_dev_config = 8'($urandom);
    end
    $display("accel test done");
    go(fa(2'h0, 1'b1), CODE_ACCEL, {STAT_NORMAL, ad}, 1);
    go(fa(2'h0, 1'b0, 1'b1), CODE_INV_ACCEL, 12'h000, 0);
    go(fr(1'b0, ADDR_STATUS, 8'h00), CODE_INV_ACCEL, 12'h000, 0);
    cb(na, 8);
    go(fa(2'h1) ^ 16'h0001, CODE_RD_DATA, {4'h0, i_rd_data}, 1);
    go(fr(1'b1, ADDR_CONTROL, 8'h33), CODE_SPI_ERR, 12'h000, 0, 15);
    go(fa(2'h2), CODE_SPI_ERR, 12'h000, 0, 16, 1'b0, 1'b1);
    go(fa(2'h2) ^ 16'h8001, CODE_SPI_ERR, 12'h000, 0);
    go(fa(2'h2) ^ 16'h0021, CODE_SPI_ERR, 12'h000, 0);
    go(fr(1'b0, 5'h01, 8'h01), CODE_SPI_ERR, 12'h000, 0);
    cb(nw, 0);
    $display("spi error test done");
    d = 8'($urandom);
    i_dev_config = 8'h80;
    go(fr(1'b1, ADDR_CONTROL, d), CODE_SPI_ERR, 12'h000, 0);
    go(fr(1'b1, 5'h0b, 8'h44), CODE_WR_ACK, {4'h0, d}, 1);
    cb(wl, {1'b1, ADDR_CONTROL, d});
    i_dev_config = 8'h00;
    go(fr(1'b1, 5'h01, 8'h44), CODE_INV_REG, 12'h000, 0);
    go(fr(1'b1, 5'h0b, d), CODE_INV_REG, 12'h000, 0, 16, 1'b1);
    cb(nw, 2);
    cb(o_readback_mismatch_flag, 1);
    go(fr(1'b0, ADDR_STATUS, 8'h00), CODE_MISO_ERR, 12'h000, 0, 16, 1'b1);
    cb(o_readback_mismatch_flag, 1);
    go(fr(1'b0, ADDR_STATUS, 8'h00), CODE_MISO_ERR, 12'h000, 0);
    cb(o_rd_addr, ADDR_STATUS);
    go(fa(2'h3), CODE_RD_DATA, {4'h0, i_rd_data}, 1);
    cb(o_readback_mismatch_flag, 0);
    $display("register test done");
    i_faults.init_pending = 1'b1;
    go(fa(2'h1), CODE_ACCEL, {STAT_NORMAL, i_accel_data}, 1);
    cb(o_pcm_disable, 1);
    go(fa(2'h1), CODE_INT_ERR, 12'h000, 0, 16, 1'b1);
    i_faults = '0;
    i_faults.sd_over = 1'b1;
    go(fa(2'h0), CODE_MISO_ERR, 12'h000, 0);
    go(fa(2'h0), CODE_ACCEL, {STAT_OVER, i_accel_data}, 1);
    cb(na, 11);
    $display("exception test done");
    results();
  end
endmodule
